// ===== cip_fsm.sv
/*
  charger input protection sequencer: power-down, settle, soft-start, short
  check and retry, overvoltage, battery and thermal shutdown, enable, fault pin.
  assumes comparator inputs carry their own hysteresis (each flag sets above
  its threshold and clears below threshold minus hysteresis) and are async.
*/
// Function
// - below input lockout: power-down, switch off, fault released
// - above lockout: reset, settle, switch on only if input and battery ok
// - soft-start raises limit in eight eighth-steps, one per step period
// - after last step sample load; over threshold starts short protection
// - no overcurrent at sample: current monitoring off for normal running
// - short-circuit switch-off ramps gate drive down, never abrupt
// - input overvoltage turns switch off at once
// - input overvoltage shutdown pulls fault low
// - input back in range: switch on again after recovery deglitch
// - battery over for longer than deglitch: soft-stop and fault low
// - battery back below threshold: restart through soft-start
// - overtemperature: switch off, fault low, restart when cooled
// - enable is active low; high forces switch off
// - fault is open drain, low during soft-stop and while switch off for a fault, else released
// - input recovery deglitch is eight milliseconds
// - battery deglitch is 176 microseconds
// - start-up overcurrent clamps and runs 5 ms check, then soft-stop if clamp still active, else run
// - after short shutdown wait 64 ms, release fault, retry soft-start
`timescale 1ns/1ns
`default_nettype none

module cip_fsm
  import cip_pkg::*;
#(
  parameter int unsigned STEP_CYC  = SS_STEP_CYC,
  parameter int unsigned REC_CYC   = IN_REC_CYC,
  parameter int unsigned CHK_CYC   = SC_CHK_CYC,
  parameter int unsigned RTY_CYC   = SC_RTY_CYC,
  parameter int unsigned STOP_CYC  = SSTOP_STEP_CYC,
  parameter int unsigned PG_CYC    = PG_SETTLE_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              input_above_lockout,
  input  wire logic              input_overvoltage,
  input  wire logic              battery_overvoltage,
  input  wire logic              die_overtemp,
  input  wire logic              load_over_short_limit,
  input  wire logic              clamp_active,
  input  wire logic              enable_n,
  output var  logic              switch_on_r,
  output var  logic [STEP_W-1:0] ilim_step_r,
  output var  logic              soft_start_r,
  output var  logic              soft_stop_r,
  output var  logic              clamp_en_r,
  output var  logic              cur_mon_en_r,
  output var  logic              fault_out_r,
  output var  logic              fault_oe_r
);

  // terminal counts, cut to counter width once
  localparam logic [CNT_W-1:0]  STEP_LAST = CNT_W'(STEP_CYC - 1);
  localparam logic [CNT_W-1:0]  REC_LAST  = CNT_W'(REC_CYC - 1);
  localparam logic [CNT_W-1:0]  CHK_LAST  = CNT_W'(CHK_CYC - 1);
  localparam logic [CNT_W-1:0]  RTY_LAST  = CNT_W'(RTY_CYC - 1);
  localparam logic [CNT_W-1:0]  STOP_LAST = CNT_W'(STOP_CYC - 1);
  localparam logic [CNT_W-1:0]  PG_LAST   = CNT_W'(PG_CYC - 1);
  localparam logic [BAT_W-1:0]  BAT_LAST  = BAT_W'(BAT_DGL_CYC - 1);
  localparam logic [STEP_W-1:0] STEP_TOP  = STEP_W'(SS_STEPS);

  typedef struct packed {
    cip_state_t        st;
    logic [CNT_W-1:0]  cnt;
    logic [BAT_W-1:0]  bat_cnt;
    logic [STEP_W-1:0] step;
    logic              stop_for_short;
    logic              ovp_seen;
    logic              sw_on;
    logic              ss;
    logic              sstop;
    logic              clamp;
    logic              mon;
    logic              fault_oe;
    logic              fault_dat;
  } cip_state_vec_t;

  cip_state_vec_t    s_r;
  cip_state_vec_t    s_nxt;
  logic [SYN_W-1:0]  raw;
  logic [SYN_W-1:0]  syn;
  logic              uv_ok;
  logic              ovp;
  logic              bat;
  logic              hot;
  logic              en;
  logic              any_hard;

  // all comparator levels and the enable pin come from outside the clock
  assign raw[I_INPUT_LOW_LOCKOUT_OK] = input_above_lockout;
  assign raw[I_IN_OVP]  = input_overvoltage;
  assign raw[I_BAT_OVP] = battery_overvoltage;
  assign raw[I_TEMP]    = die_overtemp;
  assign raw[I_LOAD_SC] = load_over_short_limit;
  assign raw[I_CLAMP]   = clamp_active;
  assign raw[I_EN_N]    = enable_n;

  cip_sync #(.WIDTH(SYN_W)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (raw),
    .sync_out (syn)
  );

  assign uv_ok    = syn[I_INPUT_LOW_LOCKOUT_OK];
  assign ovp      = syn[I_IN_OVP];
  assign bat      = syn[I_BAT_OVP];
  assign hot      = syn[I_TEMP];
  assign en       = !syn[I_EN_N];
  assign any_hard = ovp | hot;

  // next-state logic: one process covers sequencing, timers and outputs
  always_comb begin
    s_nxt          = s_r;
    s_nxt.cnt      = s_r.cnt + CNT_W'(1);
    s_nxt.bat_cnt  = '0;
    if (ovp) begin
      s_nxt.ovp_seen = 1'b1;
    end
    // battery deglitch runs only while the switch is conducting
    if (s_r.sw_on && !s_r.sstop && bat) begin
      s_nxt.bat_cnt = (s_r.bat_cnt == BAT_LAST) ? s_r.bat_cnt
                                                : s_r.bat_cnt + BAT_W'(1);
    end
    unique case (s_r.st)
      CIP_PWR_DOWN: begin
        s_nxt.cnt = '0;
        if (uv_ok) begin
          s_nxt.st = CIP_SETTLE;
        end
      end
      CIP_SETTLE: begin
        if (s_r.cnt == PG_LAST) begin
          s_nxt.cnt = '0;
          if (!en) begin
            s_nxt.st = CIP_DISABLED;
          end else if (any_hard || bat) begin
            s_nxt.st = CIP_FAULT_OFF;
          end else begin
            s_nxt.st = CIP_SOFTSTART;
          end
        end
      end
      CIP_DISABLED: begin
        s_nxt.cnt = '0;
        if (en) begin
          s_nxt.st = (any_hard || bat) ? CIP_FAULT_OFF : CIP_SOFTSTART;
        end
      end
      CIP_SOFTSTART: begin
        if (s_r.cnt == STEP_LAST) begin
          s_nxt.cnt = '0;
          if (s_r.step != STEP_TOP) begin
            s_nxt.step = s_r.step + STEP_W'(1);
          end else if (syn[I_LOAD_SC]) begin
            s_nxt.st = CIP_SC_CHECK;
          end else begin
            s_nxt.st = CIP_RUN;
          end
        end
      end
      CIP_SC_CHECK: begin
        if (s_r.cnt == CHK_LAST) begin
          s_nxt.cnt = '0;
          if (syn[I_CLAMP]) begin
            s_nxt.st             = CIP_SOFTSTOP;
            s_nxt.stop_for_short = 1'b1;
          end else begin
            s_nxt.st = CIP_RUN;
          end
        end
      end
      CIP_RUN: begin
        s_nxt.cnt = '0;
      end
      CIP_SOFTSTOP: begin
        // gate drive walks down one eighth per ramp step
        if (s_r.cnt == STOP_LAST) begin
          s_nxt.cnt = '0;
          if (s_r.step != '0) begin
            s_nxt.step = s_r.step - STEP_W'(1);
          end else if (s_r.stop_for_short && !any_hard && !bat) begin
            s_nxt.st = CIP_RETRY;
          end else begin
            s_nxt.st = CIP_FAULT_OFF;
          end
        end
      end
      CIP_RETRY: begin
        if (any_hard || bat) begin
          s_nxt.st  = CIP_FAULT_OFF;
          s_nxt.cnt = '0;
        end else if (s_r.cnt == RTY_LAST) begin
          s_nxt.st  = CIP_SOFTSTART;
          s_nxt.cnt = '0;
        end
      end
      CIP_FAULT_OFF: begin
        s_nxt.cnt = '0;
        if (!any_hard && !bat) begin
          // battery and thermal recovery go straight to soft-start
          s_nxt.st = s_r.ovp_seen ? CIP_IN_REC : CIP_SOFTSTART;
        end
      end
      CIP_IN_REC: begin
        if (any_hard || bat) begin
          s_nxt.st  = CIP_FAULT_OFF;
          s_nxt.cnt = '0;
        end else if (s_r.cnt == REC_LAST) begin
          s_nxt.st  = CIP_SOFTSTART;
          s_nxt.cnt = '0;
        end
      end
      default: begin
        s_nxt.st = CIP_PWR_DOWN;
      end
    endcase

    // conditions that override the sequence, lowest priority first
    if (s_r.sw_on && !s_r.sstop && s_r.bat_cnt == BAT_LAST && bat) begin
      s_nxt.st             = CIP_SOFTSTOP;
      s_nxt.cnt            = '0;
      s_nxt.stop_for_short = 1'b0;                     // battery stop never retries
    end
    if (any_hard && s_r.st inside {CIP_SOFTSTART, CIP_SC_CHECK, CIP_RUN,
                                   CIP_SOFTSTOP}) begin
      s_nxt.st  = CIP_FAULT_OFF;
      s_nxt.cnt = '0;
    end
    if (!en && s_r.st != CIP_PWR_DOWN && s_r.st != CIP_SETTLE) begin
      s_nxt.st  = CIP_DISABLED;
      s_nxt.cnt = '0;
    end
    if (!uv_ok) begin
      s_nxt.st  = CIP_PWR_DOWN;
      s_nxt.cnt = '0;
    end

    // entry bookkeeping
    if (s_nxt.st == CIP_SOFTSTART && s_r.st != CIP_SOFTSTART) begin
      s_nxt.step = STEP_W'(1);
      s_nxt.ovp_seen       = 1'b0;
      s_nxt.stop_for_short = 1'b0;
    end
    if (s_nxt.st inside {CIP_PWR_DOWN, CIP_SETTLE, CIP_DISABLED, CIP_FAULT_OFF,
                         CIP_IN_REC, CIP_RETRY}) begin
      s_nxt.step = '0;
    end
    if (s_nxt.st == CIP_PWR_DOWN || s_nxt.st == CIP_DISABLED) begin
      s_nxt.ovp_seen = 1'b0;
    end

    // output decode from the next state so pins leave registers directly
    s_nxt.sw_on = s_nxt.st inside {CIP_SOFTSTART, CIP_SC_CHECK, CIP_RUN,
                                   CIP_SOFTSTOP};
    s_nxt.ss    = (s_nxt.st == CIP_SOFTSTART);
    s_nxt.sstop = (s_nxt.st == CIP_SOFTSTOP);
    s_nxt.clamp = (s_nxt.st == CIP_SC_CHECK);
    // monitoring needed only until the start-up sample passes
    s_nxt.mon   = s_nxt.st inside {CIP_SOFTSTART, CIP_SC_CHECK};
    // fault held low during soft-stop and while off for a fault, never when disabled or unpowered
    s_nxt.fault_oe = s_nxt.st inside {CIP_FAULT_OFF, CIP_IN_REC, CIP_RETRY}
                     || s_nxt.st == CIP_SOFTSTOP;
    s_nxt.fault_dat = 1'b0;                            // open drain only ever pulls low
  end

  // state register; reset lands in power-down with everything off
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_r <= '{st: CIP_PWR_DOWN, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // pins come straight from the state register; enable selects the pull-down
  assign switch_on_r  = s_r.sw_on;
  assign ilim_step_r  = s_r.step;
  assign soft_start_r = s_r.ss;
  assign soft_stop_r  = s_r.sstop;
  assign clamp_en_r   = s_r.clamp;
  assign cur_mon_en_r = s_r.mon;
  assign fault_out_r  = s_r.fault_dat;
  assign fault_oe_r   = s_r.fault_oe;

endmodule // cip_fsm

`default_nettype wire

// ===== cip_pkg.sv
/*
  shared constants for the charger input protection sequencer: timing in
  printed units and derived cycle counts, step counts, state codes.
  assumes a 20 mhz core clock; analog comparators supply all level inputs except enable.
*/
package cip_pkg;

  // core clock rate
  localparam int unsigned CLK_HZ  = 20_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;

  // soft-start: eight equal current-limit steps
  localparam int unsigned SS_STEPS    = 8;
  localparam int unsigned SS_STEP_US  = 625;
  localparam int unsigned SS_STEP_CYC = SS_STEP_US * CLK_MHZ;

  // battery overvoltage deglitch
  localparam int unsigned BAT_DGL_US  = 176;
  localparam int unsigned BAT_DGL_CYC = BAT_DGL_US * CLK_MHZ;

  // input overvoltage recovery deglitch
  localparam int unsigned IN_REC_MS   = 8;
  localparam int unsigned IN_REC_CYC  = IN_REC_MS * CLK_KHZ;

  // start-up short check and retry interval
  localparam int unsigned SC_CHK_MS   = 5;
  localparam int unsigned SC_CHK_CYC  = SC_CHK_MS * CLK_KHZ;
  localparam int unsigned SC_RTY_MS   = 64;
  localparam int unsigned SC_RTY_CYC  = SC_RTY_MS * CLK_KHZ;

  // power-good settle and soft-stop ramp length (no printed figure)
  localparam int unsigned PG_SETTLE_US   = 100;
  localparam int unsigned PG_SETTLE_CYC  = PG_SETTLE_US * CLK_MHZ;
  localparam int unsigned SSTOP_US       = 400;
  localparam int unsigned SSTOP_STEP_CYC = (SSTOP_US * CLK_MHZ) / SS_STEPS;

  // counter widths
  localparam int unsigned CNT_W  = 21;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned BAT_W  = 12;

  // synchronised input vector layout
  localparam int unsigned SYN_W      = 7;
  localparam int unsigned I_INPUT_LOW_LOCKOUT_OK  = 0;
  localparam int unsigned I_IN_OVP   = 1;
  localparam int unsigned I_BAT_OVP  = 2;
  localparam int unsigned I_TEMP     = 3;
  localparam int unsigned I_LOAD_SC  = 4;
  localparam int unsigned I_CLAMP    = 5;
  localparam int unsigned I_EN_N     = 6;

  typedef enum logic [3:0] {
    CIP_PWR_DOWN  = 4'h0,
    CIP_SETTLE    = 4'h1,
    CIP_DISABLED  = 4'h2,
    CIP_SOFTSTART = 4'h3,
    CIP_SC_CHECK  = 4'h4,
    CIP_RUN       = 4'h5,
    CIP_SOFTSTOP  = 4'h6,
    CIP_RETRY     = 4'h7,
    CIP_FAULT_OFF = 4'h8,
    CIP_IN_REC    = 4'h9
  } cip_state_t;

endpackage

// ===== cip_sync.sv
/*
  two flip-flop synchroniser, one stage pair per bit.
  assumes inputs are asynchronous levels; reset value is all zero.
*/
`timescale 1ns/1ns
`default_nettype none

module cip_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // first stage feeds only the second stage
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      logic meta_r;
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          meta_r       <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          meta_r       <= async_in[gi];
          sync_out[gi] <= meta_r;
        end
      end
    end
  endgenerate

endmodule // cip_sync

`default_nettype wire

// ===== cip_host_model.sv
/*
  host processor model on the enable and fault lines of the sequencer.
  assumes the bench sets want_on off the clock edge; fault line has a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module cip_host_model (
  input  wire logic want_on,
  input  wire logic fault_oe,
  input  wire logic fault_out,
  output wire logic enable_n,
  output wire logic fault_n
);
  // gpio drives enable low to let the switch start up
  assign enable_n = !want_on;
  // released open drain reads the pull-up level, never a stale value
  assign fault_n  = fault_oe ? fault_out : 1'b1;
endmodule // cip_host_model

`default_nettype wire

// ===== cip_fsm_properties.sv
/*
  concurrent checks on the protection sequencer pins.
  assumes the bind below; comparator inputs pass two sync flops.
*/
`timescale 1ns/1ns
`default_nettype none

module cip_fsm_properties
  import cip_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              input_above_lockout,
  input wire logic              input_overvoltage,
  input wire logic              die_overtemp,
  input wire logic              enable_n,
  input wire logic              switch_on_r,
  input wire logic [STEP_W-1:0] ilim_step_r,
  input wire logic              soft_start_r,
  input wire logic              soft_stop_r,
  input wire logic              clamp_en_r,
  input wire logic              cur_mon_en_r,
  input wire logic              fault_out_r,
  input wire logic              fault_oe_r
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // three samples cover the sync flops plus the state register
  a_lockout_off: assert property ((!input_above_lockout)[*3] |=> !switch_on_r && !fault_oe_r)
    else $error("switch or fault active in lockout");
  a_enable_off: assert property (enable_n[*3] |=> !switch_on_r && !fault_oe_r)
    else $error("switch or fault active while disabled");
  a_trip_abrupt: assert property (switch_on_r ##0 ((input_overvoltage || die_overtemp)
      && !enable_n && input_above_lockout)[*3] |=> !switch_on_r && fault_oe_r && !soft_stop_r)
    else $error("trip did not cut switch with fault");
  a_start_step: assert property ($rose(soft_start_r) |-> switch_on_r && cur_mon_en_r
      && ilim_step_r == 4'h1)
    else $error("soft start not at first step");
  a_step_incr: assert property (soft_start_r && $past(soft_start_r)
      && ilim_step_r != $past(ilim_step_r) |-> ilim_step_r == $past(ilim_step_r) + 4'h1)
    else $error("soft start step not by one");
  a_run_entry: assert property ($fell(soft_start_r) && switch_on_r && !clamp_en_r && !soft_stop_r
      |-> ilim_step_r == 4'h8 && !cur_mon_en_r)
    else $error("run entered without full limit or with monitor");
  a_check_entry: assert property ($rose(clamp_en_r) |-> $past(soft_start_r)
      && $past(ilim_step_r) == 4'h8)
    else $error("short check before last step");
  a_stop_ramp: assert property (soft_stop_r && $past(soft_stop_r) |-> switch_on_r && fault_oe_r
      && ilim_step_r <= $past(ilim_step_r))
    else $error("soft stop ramp rose or dropped switch");
  a_fault_drain: assert property (fault_oe_r |-> !fault_out_r && (!switch_on_r || soft_stop_r))
    else $error("fault pin driven high or pulled low in normal running");
endmodule // cip_fsm_properties

bind cip_fsm cip_fsm_properties u_props (
  .core_clk           (core_clk),
  .nrst               (nrst),
  .input_above_lockout(input_above_lockout),
  .input_overvoltage  (input_overvoltage),
  .die_overtemp       (die_overtemp),
  .enable_n           (enable_n),
  .switch_on_r        (switch_on_r),
  .ilim_step_r        (ilim_step_r),
  .soft_start_r       (soft_start_r),
  .soft_stop_r        (soft_stop_r),
  .clamp_en_r         (clamp_en_r),
  .cur_mon_en_r       (cur_mon_en_r),
  .fault_out_r        (fault_out_r),
  .fault_oe_r         (fault_oe_r)
);

`default_nettype wire

// ===== tb_charger_input_protection_fsm.sv
/*
  self-checking bench for the protection sequencer with short timers.
  assumes cip_host_model and the bound checker; inputs move on falling edges.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_charger_input_protection_fsm
  import cip_pkg::*;
;
  localparam int STEP = 20;
  localparam int REC  = 30;
  localparam int CK   = 25;
  localparam int RTY  = 40;
  localparam int STOP = 4;
  localparam int PG   = 10;
  logic              core_clk, nrst, lock, ovp, bat, hot, load_sc, clamp, want_on;
  logic              switch_on_r, soft_start_r, soft_stop_r, clamp_en_r, cur_mon_en_r;
  logic              fault_out_r, fault_oe_r;
  logic [STEP_W-1:0] ilim_step_r;
  wire logic         enable_n, fault_n;
  int                n_errors = 0, n_compared = 0, n_cyc = 0;

  cip_fsm #(.STEP_CYC(STEP), .REC_CYC(REC), .CHK_CYC(CK), .RTY_CYC(RTY), .STOP_CYC(STOP),
    .PG_CYC(PG)) u_dut (.core_clk(core_clk), .nrst(nrst), .input_above_lockout(lock),
    .input_overvoltage(ovp), .battery_overvoltage(bat), .die_overtemp(hot),
    .load_over_short_limit(load_sc), .clamp_active(clamp), .enable_n(enable_n),
    .switch_on_r(switch_on_r), .ilim_step_r(ilim_step_r), .soft_start_r(soft_start_r),
    .soft_stop_r(soft_stop_r), .clamp_en_r(clamp_en_r), .cur_mon_en_r(cur_mon_en_r),
    .fault_out_r(fault_out_r), .fault_oe_r(fault_oe_r));
  cip_host_model u_host (.want_on(want_on), .fault_oe(fault_oe_r), .fault_out(fault_out_r),
    .enable_n(enable_n), .fault_n(fault_n));

  // clock and hang guard; the battery deglitch dominates the run length
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = switch_on_r;
      1: pick = soft_start_r;
      2: pick = soft_stop_r;
      3: pick = clamp_en_r;
      default: pick = fault_n;
    endcase
  endfunction

  // bounded wait on one output, counting falling edges
  task automatic wait_sig(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // called when soft-start begins; sc says whether a short is expected
  task automatic ramp_up(input logic sc);
    int n;
    `CHK("first step", 4'h1, ilim_step_r)
    for (int k = 2; k <= 8; k++) begin
      n = 0;
      while (ilim_step_r !== STEP_W'(k) && n < 2 * STEP) begin
        @(negedge core_clk);
        n++;
      end
      `CHK("step period", STEP, n)
    end
    wait_sig(sc ? 3 : 1, sc, 2 * STEP, n);
    `CHK("sample delay", STEP, n)
    `CHK("monitor", sc, cur_mon_en_r)
    `CHK("limit", 4'h8, ilim_step_r)
  endtask

  task automatic t_power_up();
    int n;
    repeat (8) @(negedge core_clk);
    `CHK("lockout switch", 1'b0, switch_on_r)
    `CHK("lockout fault", 1'b1, fault_n)
    lock = 1'b1;
    wait_sig(0, 1'b1, PG + 10, n);
    `CHK("settle", 1'b1, n >= PG && n <= PG + 4)
    ramp_up(1'b0);
  endtask

  task automatic t_input_trip();
    int n;
    ovp = 1'b1;
    hot = 1'b1;
    wait_sig(0, 1'b0, 8, n);
    `CHK("trip delay", 3, n)
    `CHK("trip fault", 1'b0, fault_n)
    `CHK("trip abrupt", 1'b0, soft_stop_r)
    hot = 1'b0;
    repeat (REC + 10) @(negedge core_clk);
    `CHK("held off", 2'b00, {switch_on_r, fault_n})
    ovp = 1'b0;
    wait_sig(0, 1'b1, REC + 10, n);
    `CHK("recovery", 1'b1, n >= REC && n <= REC + 5)
    `CHK("fault freed", 1'b1, fault_n)
    ramp_up(1'b0);
  endtask

  task automatic t_hot();
    int n;
    hot = 1'b1;
    wait_sig(0, 1'b0, 8, n);
    `CHK("hot off", 3, n)
    `CHK("hot fault", 1'b0, fault_n)
    hot = 1'b0;
    wait_sig(0, 1'b1, REC + 10, n);
    `CHK("hot restart", 1'b1, n <= 6)
    ramp_up(1'b0);
  endtask

  task automatic t_battery();
    int n;
    bat = 1'b1;
    wait_sig(2, 1'b1, BAT_DGL_CYC + 20, n);
    `CHK("deglitch", 1'b1, n >= BAT_DGL_CYC && n <= BAT_DGL_CYC + 5)
    `CHK("bat fault", 2'b10, {switch_on_r, fault_n})
    wait_sig(0, 1'b0, 9 * STOP + 10, n);
    `CHK("ramp length", 1'b1, n >= 8 * STOP)
    bat = 1'b0;
    wait_sig(0, 1'b1, 10, n);
    `CHK("bat restart", 1'b1, soft_start_r)
    ramp_up(1'b0);
  endtask

  // a trip while disabled must stay silent; then start into an overload
  task automatic t_enable_short();
    int n;
    want_on = 1'b0;
    wait_sig(0, 1'b0, 8, n);
    `CHK("disable", 1'b0, switch_on_r)
    ovp = 1'b1;
    repeat (10) @(negedge core_clk);
    `CHK("quiet fault", 1'b1, fault_n)
    ovp = 1'b0;
    load_sc = 1'b1;
    clamp = 1'b1;
    repeat (5) @(negedge core_clk);
    want_on = 1'b1;
    wait_sig(0, 1'b1, REC + 20, n);
    ramp_up(1'b1);
    wait_sig(2, 1'b1, CK + 5, n);
    `CHK("check timer", 1'b1, n >= CK - 1 && n <= CK + 2)
    `CHK("short fault", 1'b0, fault_n)
    wait_sig(0, 1'b0, 9 * STOP + 10, n);
    `CHK("ramped off", 4'h0, ilim_step_r)
    wait_sig(0, 1'b1, RTY + 10, n);
    `CHK("retry wait", 1'b1, n >= RTY && n <= RTY + 5)
    `CHK("retry fault", 1'b1, fault_n)
    load_sc = 1'b0;
    clamp = 1'b0;
    ramp_up(1'b0);
  endtask

  // lockout drop mid-run, battery bad at settle end, then an overload whose
  // clamp input stays low through the check timer
  task automatic t_lockout();
    int n;
    lock = 1'b0;
    bat = 1'b1;
    wait_sig(0, 1'b0, 8, n);
    `CHK("lockout off", 3, n)
    `CHK("lockout quiet", 1'b1, fault_n)
    lock = 1'b1;
    repeat (PG + 10) @(negedge core_clk);
    `CHK("settle bat", 2'b00, {switch_on_r, fault_n})
    load_sc = 1'b1;
    bat = 1'b0;
    wait_sig(1, 1'b1, 10, n);
    `CHK("bat ok start", 1'b1, switch_on_r)
    ramp_up(1'b1);
    wait_sig(3, 1'b0, CK + 5, n);
    `CHK("clamp let go", 1'b1, n >= CK - 1 && n <= CK + 2)
    `CHK("run after check", 3'b110, {switch_on_r, fault_n, cur_mon_en_r})
    load_sc = 1'b0;
  endtask

  // main sequence
  initial begin
    {nrst, lock, ovp, bat, hot, load_sc, clamp} = 7'h00;
    want_on = 1'b1;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    t_power_up();
    t_input_trip();
    t_hot();
    t_battery();
    t_enable_short();
    t_lockout();
    complete_run();
  end
endmodule // tb_charger_input_protection_fsm

`default_nettype wire
